// ===== core/xcw_pkg.sv
// package: register map, field layout, reset values and carriers for the clock watch bank
package xcw_pkg;

    // ------------------------------------------------------------------
    // register offsets (management address space)
    // ------------------------------------------------------------------
    localparam logic [15:0] CLOCK_LOSS_STATUS_ADDR = 16'h801F;
    localparam logic [15:0] AUXILIARY_RESET_CONTROL_ADDR = 16'h8020;
    localparam logic [15:0] TEST_PATTERN_SYNC_STATUS_ADDR = 16'h8021;
    localparam logic [15:0] LANE0_ERROR_CHARACTER_ADDR = 16'h8022;
    localparam logic [15:0] LANE1_ERROR_CHARACTER_ADDR = 16'h8023;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CLK312_LOSS_LSB = 4;      // lane 0..3 at bits 4..7
    localparam int CLK156_LOSS_LSB = 0;      // lane 0..3 at bits 0..3
    localparam int AUX_TX_RESET_BIT = 15;
    localparam int AUX_RX_RESET_BIT = 14;
    localparam int AUX_MUX_RESET_BIT = 13;
    localparam int PATTERN_SYNC_BIT = 15;
    localparam int ERR_CODE_MSB = 15;
    localparam int ERR_CODE_LSB = 7;

    // ------------------------------------------------------------------
    // reset values and timing counts
    // ------------------------------------------------------------------
    localparam logic [15:0] CLOCK_LOSS_STATUS_RST = 16'h0000;
    localparam logic [15:0] AUXILIARY_RESET_CONTROL_RST = 16'h0000;
    localparam logic [15:0] LANE0_ERROR_CHARACTER_RST = 16'hCE00;
    localparam logic [15:0] LANE1_ERROR_CHARACTER_RST = 16'h0000;
    localparam int CLOCK_LOSS_CYCLES = 255;  // missing-clock cycles before a flag
    localparam int LANE_COUNT = 4;
    localparam int ERR_LANE_COUNT = 2;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // one code-group: control flag plus eight-bit value
    typedef struct packed {
        logic ctrl;
        logic [7:0] value;
    } xcw_lane_char_type;

    // management register access as seen after frame decode
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } xcw_reg_req_type;

    // self-clearing auxiliary resets
    typedef struct packed {
        logic tx_path;
        logic rx_path;
        logic mux_path;
    } xcw_aux_reset_type;

endpackage : xcw_pkg

// ===== core/xcw_clock_watch.sv
// module: watchdog flagging a clock whose activity stopped for a set number of cycles
`timescale 1ns/100ps
module xcw_clock_watch #(
    parameter int LIMIT = xcw_pkg::CLOCK_LOSS_CYCLES
) (
    input wire logic mclk_i,     // system clock
    input wire logic rst_i,      // async reset, active high
    input wire logic activity_i, // divided toggle of the watched clock
    output logic lost_o          // level: no toggle for LIMIT cycles
);

    localparam int CW = $clog2(LIMIT + 1);

    // elaboration check on the limit
    if (LIMIT < 1 || LIMIT > 65535) begin : g_bad_limit
        $error("xcw_clock_watch: LIMIT out of range");
    end

    typedef struct packed {
        logic prev;
        logic [CW-1:0] cnt;
    } xcw_watch_state_type;

    xcw_watch_state_type st_r;
    xcw_watch_state_type st_nxt;

    // count idle cycles, restart on any toggle, saturate at the limit
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = activity_i;
        if (activity_i != st_r.prev) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt != CW'(LIMIT)) begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    // state register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lost_o = (st_r.cnt == CW'(LIMIT)); // flag once idle long enough

endmodule : xcw_clock_watch

// ===== core/xcw_regs.sv
// module: clock-loss, auxiliary reset, pattern sync and error character registers
//
// Summary of operation
// - Per lane, latch bit 7..4 when 312 MHz clock missing 255+ cycles.
// - Per lane, latch bit 3..0 when 156 MHz clock missing 255+ cycles.
// - Both clock watches observe transmit-side clocks only.
// - Writing one to bit 15 pulses the transmit path reset, self-clearing.
// - Writing one to bit 14 pulses the receive path reset, self-clearing.
// - Writing one to bit 13 resets double-rate, resynchronise and path mux logic.
// - Auxiliary resets never touch read/write configuration registers.
// - Pattern status bit 15 reads high once test pattern preamble recovered.
// - Error code is bits 15..7: control flag then eight-bit character.
// - On error, programmed lane character replaces data on transmit and receive.
// - Lane 0 error code resets to control 9C, register value CE00.
// - Lane 1 error code resets to zero.
`timescale 1ns/100ps
module xcw_regs #(
    parameter int LOSS_LIMIT = xcw_pkg::CLOCK_LOSS_CYCLES
) (
    input wire logic mclk_i,                                 // 50 MHz clock
    input wire logic rst_i,                                  // async reset, active high
    input wire xcw_pkg::xcw_reg_req_type reg_req_i,          // register access strobe
    output logic [15:0] reg_rdata_o,                         // read data, cycle after rd
    input wire logic [3:0] tx_clk312_activity_i,             // tx 312 MHz toggle per lane
    input wire logic [3:0] tx_clk156_activity_i,             // tx 156 MHz toggle per lane
    input wire logic pattern_sync_i,                         // checker preamble recovered
    output xcw_pkg::xcw_aux_reset_type aux_reset_o,          // one-cycle path resets
    input wire xcw_pkg::xcw_lane_char_type [1:0] tx_char_i,  // tx code-group, lanes 0..1
    input wire logic [1:0] tx_err_i,                         // tx error condition
    input wire xcw_pkg::xcw_lane_char_type [1:0] rx_char_i,  // rx code-group, lanes 0..1
    input wire logic [1:0] rx_err_i,                         // rx error condition
    output xcw_pkg::xcw_lane_char_type [1:0] tx_char_o,      // tx after substitution
    output xcw_pkg::xcw_lane_char_type [1:0] rx_char_o       // rx after substitution
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (LOSS_LIMIT < 1 || LOSS_LIMIT > 65535) begin : g_bad_limit
        $error("xcw_regs: LOSS_LIMIT out of range");
    end

    localparam int NL = xcw_pkg::LANE_COUNT;
    localparam int NE = xcw_pkg::ERR_LANE_COUNT;
    localparam int EW = xcw_pkg::ERR_CODE_MSB - xcw_pkg::ERR_CODE_LSB + 1;
    localparam logic [15:0] ERR0_RST = xcw_pkg::LANE0_ERROR_CHARACTER_RST;
    localparam logic [15:0] ERR1_RST = xcw_pkg::LANE1_ERROR_CHARACTER_RST;
    localparam logic [15:0] LOSS_RST = xcw_pkg::CLOCK_LOSS_STATUS_RST;
    localparam logic [15:0] AUX_RST = xcw_pkg::AUXILIARY_RESET_CONTROL_RST;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NL-1:0] loss312;
        logic [NL-1:0] loss156;
        xcw_pkg::xcw_aux_reset_type aux;
        xcw_pkg::xcw_lane_char_type [NE-1:0] err_code;
        logic [15:0] rdata;
        xcw_pkg::xcw_lane_char_type [NE-1:0] tx_out;
        xcw_pkg::xcw_lane_char_type [NE-1:0] rx_out;
    } xcw_regs_state_type;

    localparam xcw_regs_state_type STATE_RST = '{
        loss312: LOSS_RST[xcw_pkg::CLK312_LOSS_LSB +: NL],
        loss156: LOSS_RST[xcw_pkg::CLK156_LOSS_LSB +: NL],
        aux: '{
            tx_path: AUX_RST[xcw_pkg::AUX_TX_RESET_BIT],
            rx_path: AUX_RST[xcw_pkg::AUX_RX_RESET_BIT],
            mux_path: AUX_RST[xcw_pkg::AUX_MUX_RESET_BIT]
        },
        err_code: {
            ERR1_RST[xcw_pkg::ERR_CODE_MSB:xcw_pkg::ERR_CODE_LSB],
            ERR0_RST[xcw_pkg::ERR_CODE_MSB:xcw_pkg::ERR_CODE_LSB]
        },
        rdata: 16'h0000,
        tx_out: '0,
        rx_out: '0
    };

    xcw_regs_state_type st_r;
    xcw_regs_state_type st_nxt;

    logic [NL-1:0] lost312;
    logic [NL-1:0] lost156;

    // ------------------------------------------------------------------
    // clock watches, one pair per lane
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NL; g++) begin : g_lane
        xcw_clock_watch #(
            .LIMIT(LOSS_LIMIT)
        ) u_watch312 (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .activity_i(tx_clk312_activity_i[g]),
            .lost_o(lost312[g])
        );
        xcw_clock_watch #(
            .LIMIT(LOSS_LIMIT)
        ) u_watch156 (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .activity_i(tx_clk156_activity_i[g]),
            .lost_o(lost156[g])
        );
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    function automatic logic [15:0] read_word(input xcw_regs_state_type s,
                                              input logic [15:0] addr,
                                              input logic psync);
        logic [15:0] w;
        w = 16'h0000;
        unique case (addr)
            xcw_pkg::CLOCK_LOSS_STATUS_ADDR: begin
                w[xcw_pkg::CLK312_LOSS_LSB +: NL] = s.loss312;
                w[xcw_pkg::CLK156_LOSS_LSB +: NL] = s.loss156;
            end
            xcw_pkg::AUXILIARY_RESET_CONTROL_ADDR: begin
                w[xcw_pkg::AUX_TX_RESET_BIT] = s.aux.tx_path;
                w[xcw_pkg::AUX_RX_RESET_BIT] = s.aux.rx_path;
                w[xcw_pkg::AUX_MUX_RESET_BIT] = s.aux.mux_path;
            end
            xcw_pkg::TEST_PATTERN_SYNC_STATUS_ADDR: begin
                w[xcw_pkg::PATTERN_SYNC_BIT] = psync;
            end
            xcw_pkg::LANE0_ERROR_CHARACTER_ADDR: begin
                w[xcw_pkg::ERR_CODE_MSB:xcw_pkg::ERR_CODE_LSB] = s.err_code[0];
            end
            xcw_pkg::LANE1_ERROR_CHARACTER_ADDR: begin
                w[xcw_pkg::ERR_CODE_MSB:xcw_pkg::ERR_CODE_LSB] = s.err_code[1];
            end
            default: begin
                w = 16'h0000;  // unmapped reads as zero
            end
        endcase
        return w;
    endfunction : read_word

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic rd_loss;
        logic wr_aux;
        rd_loss = reg_req_i.rd && (reg_req_i.addr == xcw_pkg::CLOCK_LOSS_STATUS_ADDR);
        wr_aux = reg_req_i.wr && (reg_req_i.addr == xcw_pkg::AUXILIARY_RESET_CONTROL_ADDR);
        st_nxt = st_r;

        // read data captured on the read strobe, before any clear
        if (reg_req_i.rd) begin
            st_nxt.rdata = read_word(st_r, reg_req_i.addr, pattern_sync_i);
        end

        // clear on read, live loss wins
        if (rd_loss) begin
            st_nxt.loss312 = '0;
            st_nxt.loss156 = '0;
        end
        st_nxt.loss312 = st_nxt.loss312 | lost312;
        st_nxt.loss156 = st_nxt.loss156 | lost156;

        // self-clearing resets last a single cycle
        st_nxt.aux = '0;
        if (wr_aux) begin
            st_nxt.aux.tx_path = reg_req_i.wdata[xcw_pkg::AUX_TX_RESET_BIT];
            st_nxt.aux.rx_path = reg_req_i.wdata[xcw_pkg::AUX_RX_RESET_BIT];
            st_nxt.aux.mux_path = reg_req_i.wdata[xcw_pkg::AUX_MUX_RESET_BIT];
        end

        if (reg_req_i.wr && reg_req_i.addr == xcw_pkg::LANE0_ERROR_CHARACTER_ADDR) begin
            st_nxt.err_code[0] = reg_req_i.wdata[xcw_pkg::ERR_CODE_MSB:xcw_pkg::ERR_CODE_LSB];
        end
        if (reg_req_i.wr && reg_req_i.addr == xcw_pkg::LANE1_ERROR_CHARACTER_ADDR) begin
            st_nxt.err_code[1] = reg_req_i.wdata[xcw_pkg::ERR_CODE_MSB:xcw_pkg::ERR_CODE_LSB];
        end

        for (int i = 0; i < NE; i++) begin
            st_nxt.tx_out[i] = tx_err_i[i] ? st_r.err_code[i] : tx_char_i[i];
            st_nxt.rx_out[i] = rx_err_i[i] ? st_r.err_code[i] : rx_char_i[i];
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // error codes take their reset values here only
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // aux resets leave the configuration registers alone
    assign aux_reset_o = st_r.aux;
    assign reg_rdata_o = st_r.rdata;
    assign tx_char_o = st_r.tx_out;
    assign rx_char_o = st_r.rx_out;

    // unused width guard
    if (EW != 9) begin : g_bad_width
        $error("xcw_regs: error code field must be nine bits");
    end

endmodule : xcw_regs

// ===== test/xcw_regs_monitor.sv
// checker: port-level properties of the clock watch register bank
`timescale 1ns/100ps
module xcw_regs_monitor #(
    parameter int LOSS_LIMIT = xcw_pkg::CLOCK_LOSS_CYCLES
) (
    input wire logic mclk_i,                                // clock
    input wire logic rst_i,                                 // reset
    input wire xcw_pkg::xcw_reg_req_type reg_req_i,         // request
    input wire logic [15:0] reg_rdata_o,                    // read data
    input wire logic [3:0] tx_clk312_activity_i,            // 312 toggles
    input wire logic [3:0] tx_clk156_activity_i,            // 156 toggles
    input wire logic pattern_sync_i,                        // sync level
    input wire xcw_pkg::xcw_aux_reset_type aux_reset_o,     // path resets
    input wire xcw_pkg::xcw_lane_char_type [1:0] tx_char_i, // tx in
    input wire logic [1:0] tx_err_i,                        // tx error
    input wire xcw_pkg::xcw_lane_char_type [1:0] rx_char_i, // rx in
    input wire logic [1:0] rx_err_i,                        // rx error
    input wire xcw_pkg::xcw_lane_char_type [1:0] tx_char_o, // tx out
    input wire xcw_pkg::xcw_lane_char_type [1:0] rx_char_o  // rx out
);
    logic wr_aux;
    logic tx_hit;
    logic rd_hit;
    logic p312_r;
    logic p156_r;
    logic [8:0] c312_r;
    logic [8:0] c156_r;
    assign wr_aux = reg_req_i.wr && reg_req_i.addr == xcw_pkg::AUXILIARY_RESET_CONTROL_ADDR;
    assign tx_hit = wr_aux && reg_req_i.wdata[15];
    assign rd_hit = reg_req_i.rd && reg_req_i.addr == xcw_pkg::CLOCK_LOSS_STATUS_ADDR;
    // ----------------------------------------------------------------
    // stalled-cycle counters for lane 2 (312) and lane 1 (156)
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            p312_r <= 1'b0;
            p156_r <= 1'b0;
            c312_r <= 9'h000;
            c156_r <= 9'h000;
        end else begin
            p312_r <= tx_clk312_activity_i[2];
            p156_r <= tx_clk156_activity_i[1];
            c312_r <= (tx_clk312_activity_i[2] != p312_r) ? 9'h000 : c312_r + 9'(c312_r < 9'h1FF);
            c156_r <= (tx_clk156_activity_i[1] != p156_r) ? 9'h000 : c156_r + 9'(c156_r < 9'h1FF);
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_AUX_TX: assert property (tx_hit |=> aux_reset_o.tx_path)
        else $error("tx path reset missing after write");
    AST_AUX_RX: assert property (wr_aux && reg_req_i.wdata[14] |=> aux_reset_o.rx_path)
        else $error("rx path reset missing after write");
    AST_AUX_MUX: assert property (wr_aux && reg_req_i.wdata[13] |=> aux_reset_o.mux_path)
        else $error("mux reset missing after write");
    AST_AUX_SELF_CLEAR: assert property (aux_reset_o.tx_path |-> $past(tx_hit))
        else $error("tx path reset held without a write");
    AST_TX_PASS: assert property (!tx_err_i[0] |=> tx_char_o[0] == $past(tx_char_i[0]))
        else $error("tx lane 0 altered without error");
    AST_RX_PASS: assert property (!rx_err_i[1] |=> rx_char_o[1] == $past(rx_char_i[1]))
        else $error("rx lane 1 altered without error");
    AST_SYNC_READ: assert property (reg_req_i.rd && reg_req_i.addr == 16'h8021
        |=> reg_rdata_o == {$past(pattern_sync_i), 15'h0000}) else $error("sync status wrong");
    AST_UNMAPPED: assert property (reg_req_i.rd && (reg_req_i.addr < 16'h801F
        || reg_req_i.addr > 16'h8023) |=> reg_rdata_o == 16'h0000) else $error("unmapped read");
    AST_LOSS312: assert property (rd_hit && c312_r > LOSS_LIMIT + 4 |=> reg_rdata_o[6])
        else $error("312 loss flag missing");
    AST_LOSS156: assert property (rd_hit && c156_r > LOSS_LIMIT + 4 |=> reg_rdata_o[1])
        else $error("156 loss flag missing");
endmodule : xcw_regs_monitor
bind xcw_regs xcw_regs_monitor #(.LOSS_LIMIT(LOSS_LIMIT)) mon_u (.mclk_i, .rst_i, .reg_req_i,
    .reg_rdata_o, .tx_clk312_activity_i, .tx_clk156_activity_i, .pattern_sync_i, .aux_reset_o,
    .tx_char_i, .tx_err_i, .rx_char_i, .rx_err_i, .tx_char_o, .rx_char_o);

// ===== test/xcw_mgmt_host.sv
// partner: management host issuing decoded register strobes
`timescale 1ns/100ps
module xcw_mgmt_host (
    input wire logic mclk_i,                // clock
    output xcw_pkg::xcw_reg_req_type req_o, // strobes
    input wire logic [15:0] rdata_i         // read data
);
    initial req_o = '0;
    // write: hold one cycle, then drop strobe and scramble data
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        req_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge mclk_i);
        req_o.wr = 1'b0;
        req_o.wdata = ~d;
    endtask : wr
    // read: data valid the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge mclk_i);
        req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(negedge mclk_i);
        req_o.rd = 1'b0;
        d = rdata_i;
    endtask : rd
endmodule : xcw_mgmt_host

// ===== test/tb.sv
// testbench: register bank, path resets, substitution and clock loss
`timescale 1ns/100ps
module tb;
    localparam int LIM = 4;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    xcw_pkg::xcw_reg_req_type req;
    logic [15:0] rdata, got, w;
    logic [15:0] ec [2];
    logic [3:0] a312 = 4'h0, a156 = 4'h0, s312 = 4'h0, s156 = 4'h0;
    logic psync = 1'b0;
    logic [1:0] txe = 2'b00, rxe = 2'b00;
    xcw_pkg::xcw_aux_reset_type aux;
    xcw_pkg::xcw_lane_char_type [1:0] txi = '0, rxi = '0, txo, rxo;
    integer seed = 32'h6579;
    int err_total = 0;
    int tests_run = 0;
    always #10 mclk_i = ~mclk_i;
    // watched clocks toggle unless stalled
    always @(negedge mclk_i) begin
        a312 <= a312 ^ ~s312;
        a156 <= a156 ^ ~s156;
    end
    xcw_mgmt_host host_u (.mclk_i(mclk_i), .req_o(req), .rdata_i(rdata));
    xcw_regs #(.LOSS_LIMIT(LIM)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .reg_req_i(req),
        .reg_rdata_o(rdata), .tx_clk312_activity_i(a312), .tx_clk156_activity_i(a156),
        .pattern_sync_i(psync), .aux_reset_o(aux), .tx_char_i(txi), .tx_err_i(txe),
        .rx_char_i(rxi), .rx_err_i(rxe), .tx_char_o(txo), .rx_char_o(rxo));
    function automatic logic [8:0] sub(input logic e, input logic [15:0] r, input logic [8:0] c);
        return e ? r[15:7] : c;
    endfunction : sub
    task automatic check(input string n, input logic [15:0] exp, input logic [15:0] seen);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
        host_u.rd(a, got);
        check($sformatf("reg %h", a), exp, got);
    endtask : rdchk
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        print_verdict;
    end
    initial begin
        ec[0] = 16'hCE00;
        ec[1] = 16'h0000;
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_i = 1'b0;
        rdchk(xcw_pkg::LANE0_ERROR_CHARACTER_ADDR, 16'hCE00);
        rdchk(xcw_pkg::LANE1_ERROR_CHARACTER_ADDR, 16'h0000);
        // status, aux and unmapped words all read zero after reset
        for (int a = 16'h801E; a < 16'h8025; a++) begin
            if (a < 16'h8022 || a > 16'h8023) begin
                rdchk(16'(a), 16'h0000);
            end
        end
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 16'hFFFF : 16'($random(seed));
            host_u.wr(16'h8022 + 16'(i % 2), w);
            ec[i % 2] = w & 16'hFF80;
            rdchk(16'h8022 + 16'(i % 2), ec[i % 2]);
        end
        host_u.wr(16'h801F, 16'hFFFF);
        host_u.wr(16'h8021, 16'hFFFF);
        rdchk(16'h801F, 16'h0000);
        rdchk(16'h8021, 16'h0000);
        $display("test error codes done");
        for (int b = 13; b < 16; b++) begin
            host_u.wr(16'h8020, 16'h0001 << b);
            check("aux pulse", {13'h0000, 3'(1 << (b - 13))}, {13'h0000, aux});
            @(negedge mclk_i);
            check("aux clear", 16'h0000, {13'h0000, aux});
        end
        host_u.wr(16'h8020, 16'hE000);
        check("aux all", 16'h0007, {13'h0000, aux});
        rdchk(16'h8022, ec[0]);
        rdchk(16'h8023, ec[1]);
        $display("test aux resets done");
        psync = 1'b1;
        rdchk(16'h8021, 16'h8000);
        psync = 1'b0;
        rdchk(16'h8021, 16'h0000);
        $display("test pattern sync done");
        repeat (40) begin
            txi = 18'($random(seed));
            rxi = 18'($random(seed));
            txe = 2'($random(seed));
            rxe = 2'($random(seed));
            @(negedge mclk_i);
            for (int l = 0; l < 2; l++) begin
                check("tx char", {7'h00, sub(txe[l], ec[l], txi[l])}, {7'h00, txo[l]});
                check("rx char", {7'h00, sub(rxe[l], ec[l], rxi[l])}, {7'h00, rxo[l]});
            end
        end
        $display("test substitution done");
        s312 = 4'h4;
        s156 = 4'h2;
        repeat (20) @(negedge mclk_i);
        s312 = 4'h0;
        s156 = 4'h0;
        repeat (4) @(negedge mclk_i);
        rdchk(16'h801F, 16'h0042);
        rdchk(16'h801F, 16'h0000);
        s312 = 4'h4;
        s156 = 4'h2;
        repeat (20) @(negedge mclk_i);
        rdchk(16'h801F, 16'h0042);
        rdchk(16'h801F, 16'h0042);
        s312 = 4'h0;
        s156 = 4'h0;
        $display("test clock loss done");
        // mid-run reset restores the error codes and clears latched flags
        @(negedge mclk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        rst_i = 1'b0;
        rdchk(xcw_pkg::LANE0_ERROR_CHARACTER_ADDR, 16'hCE00);
        rdchk(xcw_pkg::LANE1_ERROR_CHARACTER_ADDR, 16'h0000);
        rdchk(16'h801F, 16'h0000);
        $display("test mid-run reset done");
        print_verdict;
    end
endmodule : tb
